/* File: verilog/lhp_pkg.sv */
// Constants and carrier types for the LCD host status and data port.
// Assumes a single 125 MHz system clock and host pins already synchronous to it.
package lhp_pkg;

  // System clock period in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Internal busy time after an accepted data access; plain default, not a documented figure
  localparam int unsigned BUSY_TIME_NS = 40;
  // Least time, so it rounds up to whole cycles, never below one
  localparam int unsigned BUSY_CYC_RAW = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_CYC = (BUSY_CYC_RAW < 1) ? 1 : BUSY_CYC_RAW;
  localparam int unsigned BUSY_CNT_W = 4;

  // Address counter layout: page field on top, column field below
  localparam int unsigned PAGE_W = 3;
  localparam int unsigned COL_W = 6;
  localparam int unsigned ADDR_W = PAGE_W + COL_W;
  localparam int unsigned MEM_DEPTH = 512;

  // Status word bit positions
  localparam int unsigned STAT_BUSY_POS = 7;
  localparam int unsigned STAT_ON_POS = 5;
  localparam int unsigned STAT_INIT_POS = 4;

  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [BUSY_CNT_W-1:0] BUSY_CNT_RST = 4'h0;
  localparam logic [COL_W-1:0] COL_ONE = 6'h01;

  // Display memory address: page in the upper part, column in the lower part
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0] col;
  } lhp_addr_type;

  localparam lhp_addr_type ADDR_RST = '{page: 3'h0, col: 6'h00};

  // Status word as it appears on the data lines, most significant bit first
  typedef struct packed {
    logic busy;
    logic zero6;
    logic disp_on;
    logic init;
    logic [3:0] zero_low;
  } lhp_status_type;

  // Host pin group as seen by the device
  typedef struct packed {
    logic en_strobe;
    logic rw_sel;
    logic di_sel;
    logic [7:0] data;
  } lhp_host_in_type;

  // Kinds of access selected by the two select lines
  typedef enum logic [1:0] {
    LHP_ACC_INSTR = 2'b00,
    LHP_ACC_WRITE = 2'b01,
    LHP_ACC_STAT = 2'b10,
    LHP_ACC_READ = 2'b11
  } lhp_acc_type;

endpackage

/* File: verilog/lhp_port.sv */
// Device end of the 8-bit parallel host port: status read, display data write and read.
// Assumes host pins synchronous to clk_sys and the enable strobe held high for many cycles.
// Function
// - Status read drives status while strobe high
// - Busy bit7, display bit5, init bit4
// - During init, ignore all except status read; address loads still taken, data reads still drive the latched byte
// - Data write stores byte, column increments
// - Data read drives byte, column increments
// - Column advances exactly one per read
// - While busy, ignore instructions and data; address loads still taken, data reads still drive the latched byte
// - Display bit one when display on
// - Address is 3-bit page, 6-bit column
module lhp_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lhp_pkg::lhp_host_in_type host_in,
  input wire logic display_flipflop,
  input wire logic init_active,
  input wire logic ext_busy,
  input wire logic addr_load,
  input wire lhp_pkg::lhp_addr_type addr_load_val,
  output logic [7:0] host_data_out_r,
  output logic host_data_oe_r,
  output logic busy_indicator_r,
  output lhp_pkg::lhp_addr_type addr_r
);

  // Strobe of the previous cycle, for falling edge detection
  logic e_d_r;
  logic e_d_nxt;
  // Busy countdown and its next value
  logic [lhp_pkg::BUSY_CNT_W-1:0] busy_cnt_r;
  logic [lhp_pkg::BUSY_CNT_W-1:0] busy_cnt_nxt;
  logic busy_nxt;
  // Read latch: holds the byte fetched at the end of the previous read
  logic [7:0] read_buf_r;
  logic [7:0] read_buf_nxt;
  lhp_pkg::lhp_addr_type addr_nxt;
  logic [7:0] data_out_nxt;
  logic data_oe_nxt;
  // Display memory, one byte per page and column
  logic [7:0] display_memory [lhp_pkg::MEM_DEPTH];
  // Decoded access and its acceptance
  lhp_pkg::lhp_acc_type acc;
  logic e_fall;
  logic accept;
  logic do_write;
  logic do_read;
  lhp_pkg::lhp_status_type status_word;

  // Flat index into the display memory
  function automatic logic [lhp_pkg::ADDR_W-1:0] mem_index(input lhp_pkg::lhp_addr_type a);
    mem_index = {a.page, a.col};
  endfunction

  // Access decode and status word assembly
  always_comb begin
    acc = lhp_pkg::lhp_acc_type'({host_in.rw_sel, host_in.di_sel});
    // Accesses complete on the falling edge of the strobe
    e_fall = e_d_r && !host_in.en_strobe;
    accept = e_fall && !busy_indicator_r && !init_active;
    do_write = accept && (acc == lhp_pkg::LHP_ACC_WRITE);
    do_read = accept && (acc == lhp_pkg::LHP_ACC_READ);
    status_word.busy = busy_indicator_r;
    status_word.zero6 = 1'b0;
    status_word.disp_on = display_flipflop;
    status_word.init = init_active;
    status_word.zero_low = 4'h0;
  end

  // Next state of strobe history, busy, address and read latch
  always_comb begin
    e_d_nxt = host_in.en_strobe;
    busy_cnt_nxt = busy_cnt_r;
    busy_nxt = ext_busy;
    addr_nxt = addr_r;
    read_buf_nxt = read_buf_r;
    // Busy counter runs down to zero and stops there
    if (busy_cnt_r != lhp_pkg::BUSY_CNT_RST) begin
      // Count the internal operation down
      busy_cnt_nxt = busy_cnt_r - 4'h1;
    end
    if (do_write || do_read) begin
      // An accepted data access starts the internal operation
      busy_cnt_nxt = lhp_pkg::BUSY_CYC[lhp_pkg::BUSY_CNT_W-1:0];
      // page untouched, column wraps in 6 bits
      addr_nxt.col = addr_r.col + lhp_pkg::COL_ONE;
    end
    if (do_read) begin
      // fetch for the next read, so the first read after a jump is stale
      read_buf_nxt = display_memory[mem_index(addr_r)];
    end
    if (addr_load && !do_write && !do_read) begin
      // Address load from the instruction side; a data access in the same cycle wins
      addr_nxt = addr_load_val;
    end
    // Busy reads one from the access edge until the count runs out
    busy_nxt = ext_busy || (busy_cnt_nxt != lhp_pkg::BUSY_CNT_RST);
  end

  // Data line drive: registered so the outputs come straight from flops
  always_comb begin
    data_oe_nxt = 1'b0;
    data_out_nxt = host_data_out_r;
    // drive only while strobe high on a read
    if (host_in.en_strobe && host_in.rw_sel) begin
      data_oe_nxt = 1'b1;
      if (!host_in.di_sel) begin
        data_out_nxt = status_word;
      end else begin
        // latched display byte on the lines
        data_out_nxt = read_buf_r;
      end
    end
  end

  // Register all port state except the display memory
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      e_d_r <= 1'b0;
      busy_cnt_r <= lhp_pkg::BUSY_CNT_RST;
      busy_indicator_r <= 1'b0;
      addr_r <= lhp_pkg::ADDR_RST;
      read_buf_r <= lhp_pkg::DATA_RST;
      host_data_out_r <= lhp_pkg::DATA_RST;
      host_data_oe_r <= 1'b0;
    end else begin
      e_d_r <= e_d_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      busy_indicator_r <= busy_nxt;
      addr_r <= addr_nxt;
      read_buf_r <= read_buf_nxt;
      host_data_out_r <= data_out_nxt;
      host_data_oe_r <= data_oe_nxt;
    end
  end

  // Display memory write port; contents are not cleared by reset, as in a real RAM
  always_ff @(posedge clk_sys) begin
    // store byte at page and column
    if (do_write) begin
      display_memory[mem_index(addr_r)] <= host_in.data;
    end
  end

  // Checks of the port behaviour
  a_status_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (host_in.en_strobe && host_in.rw_sel && !host_in.di_sel) |=>
      (host_data_oe_r && host_data_out_r == $past(status_word)))
    else $error("status word not driven during status read");

  a_status_layout: assert property (@(posedge clk_sys) disable iff (rst)
    (host_in.en_strobe && host_in.rw_sel && !host_in.di_sel) |=>
      (host_data_out_r[6] == 1'b0 && host_data_out_r[3:0] == 4'h0 &&
       host_data_out_r[7] == $past(busy_indicator_r) && host_data_out_r[4] == $past(init_active)))
    else $error("status word bits misplaced");

  a_init_ignore: assert property (@(posedge clk_sys) disable iff (rst)
    (e_fall && init_active && !addr_load) |=> (addr_r == $past(addr_r) && busy_cnt_r <= $past(busy_cnt_r)))
    else $error("access taken during initialization");

  a_write_store: assert property (@(posedge clk_sys) disable iff (rst)
    do_write |=> (display_memory[mem_index($past(addr_r))] == $past(host_in.data) &&
                  addr_r.col == $past(addr_r.col) + lhp_pkg::COL_ONE))
    else $error("write byte not stored or column not advanced");

  // The byte on the lines is the one latched at the end of the previous read
  a_read_return: assert property (@(posedge clk_sys) disable iff (rst)
    (host_in.en_strobe && host_in.rw_sel && host_in.di_sel) |=>
      (host_data_oe_r && host_data_out_r == $past(read_buf_r)))
    else $error("display byte not driven on read");

  // The latch takes the byte at the address that the read consumed
  a_read_fetch: assert property (@(posedge clk_sys) disable iff (rst)
    do_read |=> (read_buf_r == $past(display_memory[mem_index(addr_r)])))
    else $error("read latch did not take the addressed byte");

  a_read_incr: assert property (@(posedge clk_sys) disable iff (rst)
    do_read |=> (addr_r.col == $past(addr_r.col) + lhp_pkg::COL_ONE && addr_r.page == $past(addr_r.page)))
    else $error("column did not advance by one on read");

  a_busy_block: assert property (@(posedge clk_sys) disable iff (rst)
    (e_fall && busy_indicator_r && !addr_load) |=> (addr_r == $past(addr_r)))
    else $error("access taken while busy");

  a_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (do_write || do_read) |=> busy_indicator_r)
    else $error("busy not raised after data access");

  // Busy falls once the internal operation has run its five cycles
  // The count of five tracks the default busy time; change both together
  a_busy_release: assert property (@(posedge clk_sys) disable iff (rst)
    ((do_write || do_read) ##1 (!ext_busy)[*5]) |=> !busy_indicator_r)
    else $error("busy held past the internal operation");

  a_disp_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (host_in.en_strobe && host_in.rw_sel && !host_in.di_sel) |=> (host_data_out_r[5] == $past(display_flipflop)))
    else $error("display bit does not follow display state");

  a_release_lines: assert property (@(posedge clk_sys) disable iff (rst)
    (!host_in.en_strobe || !host_in.rw_sel) |=> !host_data_oe_r)
    else $error("data lines driven outside a read");

  // Scenarios the bench is expected to reach
  c_status_read: cover property (@(posedge clk_sys) disable iff (rst)
    e_fall && acc == lhp_pkg::LHP_ACC_STAT);
  c_write_then_read: cover property (@(posedge clk_sys) disable iff (rst)
    do_write ##[1:200] do_read);
  c_col_wrap: cover property (@(posedge clk_sys) disable iff (rst)
    do_read && addr_r.col == 6'h3F);
  c_busy_refused: cover property (@(posedge clk_sys) disable iff (rst)
    e_fall && busy_indicator_r);
  c_instr_ignored: cover property (@(posedge clk_sys) disable iff (rst)
    e_fall && acc == lhp_pkg::LHP_ACC_INSTR);

endmodule

/* File: verif/lhp_host_model.sv */
// Host processor model for the parallel port: separate strobes, shared data lines.
// Assumes the bench calls its tasks; every pin moves on a falling clock edge.
module lhp_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  output lhp_pkg::lhp_host_in_type host_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_n = 1'b1; // Read strobe, active low
  logic wr_n = 1'b1; // Write strobe, active low
  logic rw = 1'b1; // Read/write select
  logic di = 1'b0; // Data/instruction select
  logic [7:0] drv = 8'h00; // Host write value
  logic drv_on = 1'b0; // Host drives the lines, held one cycle past the strobe
  logic [7:0] bus; // Resolved data line level
  // No pull-ups: a floating bus shows the inverse of the last host value
  assign bus = dev_oe ? dev_data : (drv_on ? drv : ~drv);
  assign host_in = '{en_strobe: ~(rd_n & wr_n), rw_sel: rw, di_sel: di, data: bus};

  // One access: selects set up first, strobe held three cycles each way
  task automatic acc(input logic r, input logic d_i, input logic [7:0] v,
                     output logic [7:0] q, output logic oe_hi);
    @(negedge clk_sys);
    rw = r;
    di = d_i;
    drv = v;
    @(negedge clk_sys);
    rd_n = ~r;
    wr_n = r;
    drv_on = ~r;
    repeat (3) @(negedge clk_sys);
    q = bus;
    oe_hi = dev_oe;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // Write data stays one cycle past the strobe, where the device samples it
    @(negedge clk_sys);
    drv_on = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic poll(output logic ok);
    logic [7:0] q;
    logic o;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      acc(1'b1, 1'b0, 8'h00, q, o);
      ok = (q[7] === 1'b0) && (q[4] === 1'b0);
    end
  endtask
endmodule

/* File: verif/tb_lcd_host_status_data_port.sv */
// Self-checking bench for the parallel host port: status, write, read, refusals.
// Assumes the host model drives the pins; side inputs are driven here.
module tb_lcd_host_status_data_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0; // 125 MHz system clock
  logic rst = 1'b1; // Synchronous reset
  lhp_pkg::lhp_host_in_type host_in; // Host pins
  logic display_flipflop = 1'b0; // Display on state
  logic init_active = 1'b0; // Initialization indicator
  logic ext_busy = 1'b0; // Busy from other operations
  logic addr_load = 1'b0; // Address load pulse
  lhp_pkg::lhp_addr_type addr_load_val = '{page: 3'h0, col: 6'h00};
  logic [7:0] host_data_out_r; // Device data
  logic host_data_oe_r; // Device drive enable
  logic busy_indicator_r; // Busy flag
  lhp_pkg::lhp_addr_type addr_r; // Address counter
  int num_errors = 0; // Mismatches
  int check_count = 0; // Comparisons
  logic [7:0] q; // Data seen by the host
  logic oe; // Drive enable seen by the host

  always #4 clk_sys = ~clk_sys;

  lhp_port u_lhp_port (.clk_sys(clk_sys), .rst(rst), .host_in(host_in),
    .display_flipflop(display_flipflop), .init_active(init_active), .ext_busy(ext_busy),
    .addr_load(addr_load), .addr_load_val(addr_load_val), .host_data_out_r(host_data_out_r),
    .host_data_oe_r(host_data_oe_r), .busy_indicator_r(busy_indicator_r), .addr_r(addr_r));
  lhp_host_model u_lhp_host_model (.clk_sys(clk_sys), .dev_data(host_data_out_r),
    .dev_oe(host_data_oe_r), .host_in(host_in));

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic err(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [8:0] g, input logic [8:0] e, input string m);
    check_count++;
    if (g !== e) err(m);
  endtask

  // Bounded poll; a stuck busy ends the run
  task automatic ready;
    logic ok;
    u_lhp_host_model.poll(ok);
    if (ok !== 1'b1) begin
      err("busy never cleared");
      test_done();
    end
  endtask

  task automatic load(input logic [8:0] a);
    @(negedge clk_sys);
    addr_load = 1'b1;
    addr_load_val = a;
    @(negedge clk_sys);
    addr_load = 1'b0;
  endtask

  // Every display and init combination, then busy from outside
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      display_flipflop = i[1];
      init_active = i[0];
      u_lhp_host_model.acc(1'b1, 1'b0, 8'h00, q, oe);
      chk({1'b0, q}, {3'h0, i[1], i[0], 4'h0}, "status word");
      chk({8'h00, oe}, 9'h001, "status not driven");
    end
    init_active = 1'b0;
    display_flipflop = 1'b0;
    ext_busy = 1'b1;
    u_lhp_host_model.acc(1'b1, 1'b0, 8'h00, q, oe);
    chk({1'b0, q}, 9'h080, "busy bit");
    ext_busy = 1'b0;
    ready();
  endtask

  // Writes across the column wrap, then dummy read and read back
  task automatic t_wr_rd;
    load(9'h0BE);
    u_lhp_host_model.acc(1'b0, 1'b1, 8'hA5, q, oe);
    chk({8'h00, oe}, 9'h000, "driven on write");
    chk({8'h00, busy_indicator_r}, 9'h001, "busy after write");
    ready();
    u_lhp_host_model.acc(1'b0, 1'b1, 8'h3C, q, oe);
    ready();
    chk(addr_r, 9'h080, "write address");
    u_lhp_host_model.acc(1'b0, 1'b1, 8'h69, q, oe);
    ready();
    load(9'h0BE);
    u_lhp_host_model.acc(1'b1, 1'b1, 8'h00, q, oe);
    ready();
    u_lhp_host_model.acc(1'b1, 1'b1, 8'h00, q, oe);
    chk({1'b0, q}, 9'h0A5, "read first byte");
    ready();
    u_lhp_host_model.acc(1'b1, 1'b1, 8'h00, q, oe);
    chk({1'b0, q}, 9'h03C, "read second byte");
    chk({8'h00, host_data_oe_r}, 9'h000, "driven after strobe");
    ready();
    chk(addr_r, 9'h081, "read address");
  endtask

  // Instruction writes, writes during init and during busy leave the address alone
  task automatic t_refuse;
    u_lhp_host_model.acc(1'b0, 1'b0, 8'hB8, q, oe);
    chk(addr_r, 9'h081, "instruction taken as data");
    init_active = 1'b1;
    u_lhp_host_model.acc(1'b0, 1'b1, 8'h11, q, oe);
    u_lhp_host_model.acc(1'b1, 1'b0, 8'h00, q, oe);
    chk({1'b0, q}, 9'h010, "init status");
    chk(addr_r, 9'h081, "write taken in init");
    init_active = 1'b0;
    ext_busy = 1'b1;
    u_lhp_host_model.acc(1'b0, 1'b1, 8'h22, q, oe);
    chk(addr_r, 9'h081, "write taken while busy");
    ext_busy = 1'b0;
    ready();
  endtask

  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    t_status();
    t_wr_rd();
    t_refuse();
    test_done();
  end
endmodule
